// [uie_pkg.sv]
// constants shared by the interrupt-enable and status block
package uie_pkg;
  // register addresses on the three address lines
  localparam logic [2:0] ADDR_DATA = 3'h0;
  localparam logic [2:0] ADDR_IER = 3'h1;
  localparam logic [2:0] ADDR_ISR = 3'h2;
  localparam logic [2:0] ADDR_LCR = 3'h3;
  localparam logic [2:0] ADDR_MCR = 3'h4;
  localparam logic [2:0] ADDR_LSR = 3'h5;
  localparam logic [2:0] ADDR_MSR = 3'h6;
  localparam logic [2:0] ADDR_SPR = 3'h7;
  localparam logic [2:0] ADDR_EFR = 3'h2;
  localparam logic [2:0] ADDR_RES1 = 3'h4;
  localparam logic [2:0] ADDR_RES2 = 3'h5;
  localparam logic [2:0] ADDR_PAUSE1 = 3'h6;
  localparam logic [2:0] ADDR_PAUSE2 = 3'h7;
  // line control value that opens the enhanced bank
  localparam logic [7:0] LCR_ACCESS_KEY = 8'hbf;
  localparam int LCR_DLAB_BIT = 7;
  // field positions
  localparam int EFR_GATE_BIT = 4;
  localparam int IER_RXRDY_BIT = 0;
  localparam int IER_TXRDY_BIT = 1;
  localparam int IER_LINE_BIT = 2;
  localparam int IER_MODEM_BIT = 3;
  localparam int IER_SLEEP_BIT = 4;
  localparam int IER_XOFF_BIT = 5;
  localparam int FCR_EN_BIT = 0;
  localparam int FCR_RXRST_BIT = 1;
  localparam int FCR_TXRST_BIT = 2;
  // reset values
  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic [7:0] ISR_RST = 8'h01;
  // receive trigger levels, select 00..11
  localparam int RX_TRIG_0 = 8;
  localparam int RX_TRIG_1 = 16;
  localparam int RX_TRIG_2 = 24;
  localparam int RX_TRIG_3 = 28;
  // transmit trigger levels, select 00..11, and gate-off level
  localparam int TX_TRIG_0 = 16;
  localparam int TX_TRIG_1 = 8;
  localparam int TX_TRIG_2 = 24;
  localparam int TX_TRIG_3 = 30;
  localparam int TX_TRIG_OFF = 1;
  // interrupt status codes, bits 5:0
  localparam logic [5:0] ISR_NONE = 6'h01;
  localparam logic [5:0] ISR_LINE = 6'h06;
  localparam logic [5:0] ISR_TOUT = 6'h0c;
  localparam logic [5:0] ISR_RXRDY = 6'h04;
  localparam logic [5:0] ISR_TXRDY = 6'h02;
  localparam logic [5:0] ISR_MODEM = 6'h00;
  localparam logic [5:0] ISR_XOFF = 6'h10;
  // receive time-out: characters plus bits
  localparam int TOUT_CHARS = 4;
  localparam int TOUT_BITS = 12;
  localparam int START_BITS = 1;
  localparam int MIN_DATA_BITS = 5;
endpackage

// [uie_int_prio.sv]
// priority encoder for the interrupt status code
`timescale 1ns/1ps
module uie_int_prio (
  // enabled pending sources
  input wire logic line_in,
  input wire logic tout_in,
  input wire logic rxrdy_in,
  input wire logic txrdy_in,
  input wire logic modem_in,
  input wire logic xoff_in,
  // encoded status
  output logic [5:0] code_out
);
  ////////////////////////////////////////////////////////////////////
  // highest level wins, none gives the idle code
  always_comb begin
    if (line_in) begin
      code_out = uie_pkg::ISR_LINE;
    end else if (tout_in) begin
      code_out = uie_pkg::ISR_TOUT;
    end else if (rxrdy_in) begin
      code_out = uie_pkg::ISR_RXRDY;
    end else if (txrdy_in) begin
      code_out = uie_pkg::ISR_TXRDY;
    end else if (modem_in) begin
      code_out = uie_pkg::ISR_MODEM;
    end else if (xoff_in) begin
      code_out = uie_pkg::ISR_XOFF;
    end else begin
      code_out = uie_pkg::ISR_NONE;
    end
  end
endmodule

// [uie_rx_timeout.sv]
// receive time-out timer counted in bit times
`timescale 1ns/1ps
module uie_rx_timeout #(
  parameter int CNT_W = 8
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // control
  input wire logic armed_in,
  input wire logic restart_in,
  input wire logic bit_tick_in,
  input wire logic [3:0] frame_in,
  // flag
  output logic expired_out
);
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;
  logic flag_reg;
  logic flag_next;
  logic [CNT_W-1:0] char_bits;
  logic [CNT_W-1:0] limit;
  logic hit;

  ////////////////////////////////////////////////////////////////////
  // character length: start, data, parity, stop
  always_comb begin
    char_bits = CNT_W'(uie_pkg::START_BITS + uie_pkg::MIN_DATA_BITS + 1)
      + CNT_W'(frame_in[1:0]) + CNT_W'(frame_in[3]) + CNT_W'(frame_in[2]);
    limit = CNT_W'(uie_pkg::TOUT_CHARS * char_bits + uie_pkg::TOUT_BITS);
  end

  // count idle bit times while data waits unread
  always_comb begin
    hit = armed_in && !restart_in && bit_tick_in && (cnt_reg + 1'b1 >= limit);
    cnt_next = cnt_reg;
    if (!armed_in || restart_in) begin
      cnt_next = '0;
    end else if (bit_tick_in && cnt_reg < limit) begin
      cnt_next = cnt_reg + 1'b1;
    end
    flag_next = hit || (flag_reg && armed_in && !restart_in);
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_reg <= '0;
      flag_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      flag_reg <= flag_next;
    end
  end

  assign expired_out = flag_reg;
endmodule

// [uie_top.sv]
// interrupt-enable, status and enhanced register bank of one channel
// Notes on behaviour
// - upper enable, status, transmit trigger, modem bits and fraction need gate
// - enhanced and flow characters reachable only under the access key
// - fifo mode receive interrupt follows level at or above trigger
// - data ready set on first stored character, cleared when empty
// - line status bit one flags a receive overrun
// - bits two to four show errors of the byte at the head
// - bit five holding empty, bit six holding and shifter empty
// - bit seven set when any stored character carries an error
// - receive interrupt on held byte, or trigger level in fifo mode
// - transmit interrupt on holding empty or level below trigger
// - enabling transmit interrupt while empty raises it at once
// - line status interrupt when any of bits one to four set
// - overrun interrupts at once, errors when byte reaches the head
// - modem change interrupt gated by enable bit three
// - enable bit four is sleep, only with the gate bit set
// - enable bit five is xoff interrupt, only with gate bit
// - all enables zero after reset
// - only enabled sources appear in interrupt status
// - status bit zero is one when nothing pending
// - fifo mode time-out after four characters plus twelve bits unread
`timescale 1ns/1ps
module uie_top #(
  parameter int LVL_W = 6
) (
  // clock and reset
  input wire logic CORE_CLK_IN,
  input wire logic RST_N_IN,
  // host register bus
  input wire logic CS_IN,
  input wire logic RD_IN,
  input wire logic WR_IN,
  input wire logic [2:0] ADDR_IN,
  input wire logic [7:0] DATA_IN,
  output logic [7:0] DATA_OUT,
  // receiver side
  input wire logic [LVL_W-1:0] RX_LEVEL_IN,
  input wire logic [7:0] RX_DATA_IN,
  input wire logic RX_PUSH_IN,
  input wire logic RX_OVERRUN_IN,
  input wire logic [2:0] RX_HEAD_ERR_IN,
  input wire logic RX_ANY_ERR_IN,
  input wire logic BIT_TICK_IN,
  // transmitter side
  input wire logic [LVL_W-1:0] TX_LEVEL_IN,
  input wire logic TSR_EMPTY_IN,
  // modem and flow control
  input wire logic [7:0] MSR_IN,
  input wire logic XOFF_DET_IN,
  input wire logic XON_DET_IN,
  // strobes to the datapath
  output logic RX_POP_OUT,
  output logic TX_PUSH_OUT,
  output logic [7:0] TX_DATA_OUT,
  output logic MSR_READ_OUT,
  output logic RX_FIFO_RST_OUT,
  output logic TX_FIFO_RST_OUT,
  // configuration
  output logic FIFO_EN_OUT,
  output logic SLEEP_EN_OUT,
  output logic [7:0] LCR_OUT,
  output logic [7:0] MCR_OUT,
  output logic [7:0] EFR_OUT,
  output logic [31:0] FLOW_CHARS_OUT,
  output logic [15:0] DIVISOR_OUT,
  output logic [7:0] FRAC_DIV_OUT,
  // interrupt
  output logic INT_OUT
);
  // trigger level for a two-bit select
  function automatic logic [LVL_W-1:0] trig(input logic [1:0] sel,
                                            input logic rx);
    int v;
    unique case (sel)
      2'h0: v = rx ? uie_pkg::RX_TRIG_0 : uie_pkg::TX_TRIG_0;
      2'h1: v = rx ? uie_pkg::RX_TRIG_1 : uie_pkg::TX_TRIG_1;
      2'h2: v = rx ? uie_pkg::RX_TRIG_2 : uie_pkg::TX_TRIG_2;
      2'h3: v = rx ? uie_pkg::RX_TRIG_3 : uie_pkg::TX_TRIG_3;
    endcase
    return LVL_W'(v);
  endfunction

  logic [7:0] ier_reg, ier_next, efr_reg, efr_next, lcr_reg, lcr_next;
  logic [7:0] mcr_reg, mcr_next, fcr_reg, fcr_next, spr_reg, spr_next;
  logic [7:0] dll_reg, dll_next, dlm_reg, dlm_next, dld_reg, dld_next;
  logic [7:0] res1_reg, res1_next, res2_reg, res2_next;
  logic [7:0] pause1_reg, pause1_next, pause2_reg, pause2_next;
  logic [7:0] dout_reg, dout_next, txd_reg, txd_next;
  logic pop_reg, pop_next, push_reg, push_next, msrrd_reg, msrrd_next;
  logic rxrst_reg, rxrst_next, txrst_reg, txrst_next;
  logic ovr_reg, ovr_next, errp_reg, errp_next, herr_reg, herr_next;
  logic txi_reg, txi_next, below_reg, below_next, ier1_reg, ier1_next;
  logic xoff_reg, xoff_next, int_reg, int_next, slp_reg, slp_next;
  logic [7:0] isr_reg, isr_next;
  logic wr, rd, key, dlab, gate, fifo_en;
  logic [7:0] ier_eff, line_status_register, rd_data;
  logic [5:0] code;
  logic rx_any, tx_below, head_err, tout;
  logic src_line, src_tout, src_rx, src_tx, src_modem, src_xoff;

  ////////////////////////////////////////////////////////////////////
  // access decode
  always_comb begin
    wr = CS_IN && WR_IN;
    rd = CS_IN && RD_IN;
    key = (lcr_reg == uie_pkg::LCR_ACCESS_KEY);
    dlab = lcr_reg[uie_pkg::LCR_DLAB_BIT];
    gate = efr_reg[uie_pkg::EFR_GATE_BIT];
    fifo_en = fcr_reg[uie_pkg::FCR_EN_BIT];
    ier_eff = gate ? ier_reg : {4'h0, ier_reg[3:0]};
  end

  // line status view
  always_comb begin
    rx_any = (RX_LEVEL_IN != '0);
    head_err = rx_any && (RX_HEAD_ERR_IN != 3'h0);
    line_status_register[0] = rx_any;
    line_status_register[1] = ovr_reg;
    line_status_register[4:2] = rx_any ? RX_HEAD_ERR_IN : 3'h0;
    line_status_register[5] = (TX_LEVEL_IN == '0);
    line_status_register[6] = line_status_register[5] && TSR_EMPTY_IN;
    line_status_register[7] = RX_ANY_ERR_IN;
  end

  ////////////////////////////////////////////////////////////////////
  // read data mux
  always_comb begin
    rd_data = 8'h00;
    unique case (ADDR_IN)
      uie_pkg::ADDR_DATA: rd_data = dlab ? dll_reg : RX_DATA_IN;
      uie_pkg::ADDR_IER: rd_data = dlab ? dlm_reg : ier_eff;
      uie_pkg::ADDR_ISR: begin
        if (key) begin
          rd_data = efr_reg;
        end else if (dlab) begin
          rd_data = gate ? dld_reg : 8'h00;
        end else begin
          rd_data = isr_reg;
        end
      end
      uie_pkg::ADDR_LCR: rd_data = lcr_reg;
      uie_pkg::ADDR_MCR: rd_data = key ? res1_reg : mcr_reg;
      uie_pkg::ADDR_LSR: rd_data = key ? res2_reg : line_status_register;
      uie_pkg::ADDR_MSR: rd_data = key ? pause1_reg : MSR_IN;
      uie_pkg::ADDR_SPR: rd_data = key ? pause2_reg : spr_reg;
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // register writes and bus strobes
  always_comb begin
    ier_next = ier_reg;
    efr_next = efr_reg;
    lcr_next = lcr_reg;
    mcr_next = mcr_reg;
    fcr_next = fcr_reg;
    spr_next = spr_reg;
    dll_next = dll_reg;
    dlm_next = dlm_reg;
    dld_next = dld_reg;
    res1_next = res1_reg;
    res2_next = res2_reg;
    pause1_next = pause1_reg;
    pause2_next = pause2_reg;
    txd_next = txd_reg;
    push_next = 1'b0;
    rxrst_next = 1'b0;
    txrst_next = 1'b0;
    pop_next = rd && !dlab && (ADDR_IN == uie_pkg::ADDR_DATA);
    msrrd_next = rd && !key && (ADDR_IN == uie_pkg::ADDR_MSR);
    dout_next = rd ? rd_data : dout_reg;
    if (wr) begin
      unique case (ADDR_IN)
        uie_pkg::ADDR_DATA: begin
          if (dlab) begin
            dll_next = DATA_IN;
          end else begin
            txd_next = DATA_IN;
            push_next = 1'b1;
          end
        end
        uie_pkg::ADDR_IER: begin
          if (dlab) begin
            dlm_next = DATA_IN;
          end else if (gate) begin
            ier_next = DATA_IN;
          end else begin
            ier_next = {ier_reg[7:4], DATA_IN[3:0]};
          end
        end
        uie_pkg::ADDR_ISR: begin
          if (key) begin
            efr_next = DATA_IN;
          end else if (dlab) begin
            if (gate) begin
              dld_next = DATA_IN;
            end
          end else if (DATA_IN[uie_pkg::FCR_EN_BIT]) begin
            fcr_next = DATA_IN;
            if (!gate) begin
              fcr_next[5:4] = fcr_reg[5:4];
            end
            fcr_next[2:1] = 2'h0;
            rxrst_next = DATA_IN[uie_pkg::FCR_RXRST_BIT];
            txrst_next = DATA_IN[uie_pkg::FCR_TXRST_BIT];
          end else begin
            fcr_next[uie_pkg::FCR_EN_BIT] = 1'b0;
          end
        end
        uie_pkg::ADDR_LCR: lcr_next = DATA_IN;
        uie_pkg::ADDR_MCR: begin
          if (key) begin
            res1_next = DATA_IN;
          end else if (gate) begin
            mcr_next = DATA_IN;
          end else begin
            mcr_next = {mcr_reg[7:5], DATA_IN[4:0]};
          end
        end
        uie_pkg::ADDR_LSR: begin
          if (key) begin
            res2_next = DATA_IN;
          end
        end
        uie_pkg::ADDR_MSR: begin
          if (key) begin
            pause1_next = DATA_IN;
          end
        end
        uie_pkg::ADDR_SPR: begin
          if (key) begin
            pause2_next = DATA_IN;
          end else begin
            spr_next = DATA_IN;
          end
        end
      endcase
    end
  end

  always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      ier_reg <= uie_pkg::REG_RST;
      efr_reg <= uie_pkg::REG_RST;
      lcr_reg <= uie_pkg::REG_RST;
      mcr_reg <= uie_pkg::REG_RST;
      fcr_reg <= uie_pkg::REG_RST;
      spr_reg <= uie_pkg::REG_RST;
      dll_reg <= uie_pkg::REG_RST;
      dlm_reg <= uie_pkg::REG_RST;
      dld_reg <= uie_pkg::REG_RST;
      res1_reg <= uie_pkg::REG_RST;
      res2_reg <= uie_pkg::REG_RST;
      pause1_reg <= uie_pkg::REG_RST;
      pause2_reg <= uie_pkg::REG_RST;
      txd_reg <= uie_pkg::REG_RST;
      dout_reg <= uie_pkg::REG_RST;
      push_reg <= 1'b0;
      pop_reg <= 1'b0;
      msrrd_reg <= 1'b0;
      rxrst_reg <= 1'b0;
      txrst_reg <= 1'b0;
    end else begin
      ier_reg <= ier_next;
      efr_reg <= efr_next;
      lcr_reg <= lcr_next;
      mcr_reg <= mcr_next;
      fcr_reg <= fcr_next;
      spr_reg <= spr_next;
      dll_reg <= dll_next;
      dlm_reg <= dlm_next;
      dld_reg <= dld_next;
      res1_reg <= res1_next;
      res2_reg <= res2_next;
      pause1_reg <= pause1_next;
      pause2_reg <= pause2_next;
      txd_reg <= txd_next;
      dout_reg <= dout_next;
      push_reg <= push_next;
      pop_reg <= pop_next;
      msrrd_reg <= msrrd_next;
      rxrst_reg <= rxrst_next;
      txrst_reg <= txrst_next;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // receive time-out timer, restarted by arrival or read
  uie_rx_timeout u_tout (
    .clk_in(CORE_CLK_IN),
    .rst_n_in(RST_N_IN),
    .armed_in(fifo_en && rx_any),
    .restart_in(RX_PUSH_IN || pop_next),
    .bit_tick_in(BIT_TICK_IN),
    .frame_in(lcr_reg[3:0]),
    .expired_out(tout)
  );

  // enabled sources feeding the status code
  always_comb begin
    tx_below = !fifo_en ? line_status_register[5] : TX_LEVEL_IN < (gate ?
      trig(fcr_reg[5:4], 1'b0) : LVL_W'(uie_pkg::TX_TRIG_OFF));
    src_line = ier_eff[uie_pkg::IER_LINE_BIT] && (ovr_reg || errp_reg);
    src_tout = ier_eff[uie_pkg::IER_RXRDY_BIT] && tout;
    src_rx = ier_eff[uie_pkg::IER_RXRDY_BIT] && (fifo_en ?
             RX_LEVEL_IN >= trig(fcr_reg[7:6], 1'b1) : rx_any);
    src_tx = ier_eff[uie_pkg::IER_TXRDY_BIT] && txi_reg;
    src_modem = ier_eff[uie_pkg::IER_MODEM_BIT] && (MSR_IN[3:0] != 4'h0);
    src_xoff = ier_eff[uie_pkg::IER_XOFF_BIT] && xoff_reg;
  end

  uie_int_prio u_prio (
    .line_in(src_line),
    .tout_in(src_tout),
    .rxrdy_in(src_rx),
    .txrdy_in(src_tx),
    .modem_in(src_modem),
    .xoff_in(src_xoff),
    .code_out(code)
  );

  ////////////////////////////////////////////////////////////////////
  // sticky status flags; a set beats a clear in the same cycle
  always_comb begin
    logic lsr_rd, isr_rd;
    lsr_rd = rd && !key && (ADDR_IN == uie_pkg::ADDR_LSR);
    isr_rd = rd && !key && !dlab && (ADDR_IN == uie_pkg::ADDR_ISR);
    herr_next = head_err;
    below_next = tx_below;
    ier1_next = ier_eff[uie_pkg::IER_TXRDY_BIT];
    ovr_next = RX_OVERRUN_IN || (ovr_reg && !lsr_rd);
    errp_next = (head_err && !herr_reg) || (errp_reg && !lsr_rd);
    txi_next = txi_reg;
    if (isr_rd && isr_reg[5:0] == uie_pkg::ISR_TXRDY || push_next) begin
      txi_next = 1'b0;
    end
    if ((tx_below && !below_reg) || (ier_eff[uie_pkg::IER_TXRDY_BIT]
        && !ier1_reg && tx_below)) begin
      txi_next = 1'b1;
    end
    xoff_next = xoff_reg;
    if ((isr_rd && isr_reg[5:0] == uie_pkg::ISR_XOFF) || XON_DET_IN) begin
      xoff_next = 1'b0;
    end
    if (XOFF_DET_IN) begin
      xoff_next = 1'b1;
    end
    isr_next = {{2{fifo_en}}, code};
    int_next = (code != uie_pkg::ISR_NONE);
    slp_next = ier_next[uie_pkg::IER_SLEEP_BIT]
      && efr_next[uie_pkg::EFR_GATE_BIT];
  end

  always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      ovr_reg <= 1'b0;
      errp_reg <= 1'b0;
      herr_reg <= 1'b0;
      txi_reg <= 1'b0;
      below_reg <= 1'b0;
      ier1_reg <= 1'b0;
      xoff_reg <= 1'b0;
      isr_reg <= uie_pkg::ISR_RST;
      int_reg <= 1'b0;
      slp_reg <= 1'b0;
    end else begin
      ovr_reg <= ovr_next;
      errp_reg <= errp_next;
      herr_reg <= herr_next;
      txi_reg <= txi_next;
      below_reg <= below_next;
      ier1_reg <= ier1_next;
      xoff_reg <= xoff_next;
      isr_reg <= isr_next;
      int_reg <= int_next;
      slp_reg <= slp_next;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // outputs, all from flip-flops
  assign DATA_OUT = dout_reg;
  assign INT_OUT = int_reg;
  assign RX_POP_OUT = pop_reg;
  assign TX_PUSH_OUT = push_reg;
  assign TX_DATA_OUT = txd_reg;
  assign MSR_READ_OUT = msrrd_reg;
  assign RX_FIFO_RST_OUT = rxrst_reg;
  assign TX_FIFO_RST_OUT = txrst_reg;
  assign FIFO_EN_OUT = fcr_reg[uie_pkg::FCR_EN_BIT];
  assign SLEEP_EN_OUT = slp_reg;
  assign LCR_OUT = lcr_reg;
  assign MCR_OUT = mcr_reg;
  assign EFR_OUT = efr_reg;
  assign FLOW_CHARS_OUT = {pause2_reg, pause1_reg, res2_reg, res1_reg};
  assign DIVISOR_OUT = {dlm_reg, dll_reg};
  assign FRAC_DIV_OUT = dld_reg;
endmodule

// [uie_asserts.sv]
// assertion checker for the interrupt block
`timescale 1ns/1ps
module uie_asserts #(
  parameter int LVL_W = 6
) (
  // clock, reset and bus
  input wire logic CORE_CLK_IN,
  input wire logic RST_N_IN,
  input wire logic CS_IN,
  input wire logic RD_IN,
  input wire logic WR_IN,
  input wire logic [2:0] ADDR_IN,
  input wire logic [7:0] DATA_IN,
  input wire logic [7:0] DATA_OUT,
  // status sources
  input wire logic [LVL_W-1:0] RX_LEVEL_IN,
  input wire logic RX_OVERRUN_IN,
  input wire logic [2:0] RX_HEAD_ERR_IN,
  input wire logic RX_ANY_ERR_IN,
  input wire logic [LVL_W-1:0] TX_LEVEL_IN,
  input wire logic TSR_EMPTY_IN,
  input wire logic [7:0] MSR_IN,
  // configuration and interrupt
  input wire logic SLEEP_EN_OUT,
  input wire logic [7:0] LCR_OUT,
  input wire logic [7:0] EFR_OUT,
  input wire logic [31:0] FLOW_CHARS_OUT,
  input wire logic [7:0] FRAC_DIV_OUT,
  input wire logic INT_OUT
);
  logic [7:0] mask_reg;
  logic [7:0] mask_next;
  ////////////////////////////////////////////////////////////////////////
  // mirror of the enable bits, upper half only with the gate bit
  always_comb begin
    mask_next = mask_reg;
    if (CS_IN && WR_IN && ADDR_IN == 3'h1 && !LCR_OUT[7]) begin
      mask_next = EFR_OUT[4] ? DATA_IN : {mask_reg[7:4], DATA_IN[3:0]};
    end
  end
  always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      mask_reg <= 8'h00;
    end else begin
      mask_reg <= mask_next;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  default clocking @(posedge CORE_CLK_IN); endclocking
  default disable iff (!RST_N_IN);
  sequence s_line_rd;
    CS_IN && RD_IN && ADDR_IN == 3'h5 && !LCR_OUT[7];
  endsequence
  sequence s_stat_rd;
    CS_IN && RD_IN && ADDR_IN == 3'h2 && !LCR_OUT[7];
  endsequence
  sequence s_quiet;
    (mask_reg == 8'h00) [*3];
  endsequence
  chk_sleep_follow: assert property (
    (mask_reg[4] && EFR_OUT[4]) [*2] |-> SLEEP_EN_OUT)
    else $error("sleep enable missing");
  chk_frac_lock: assert property (
    !EFR_OUT[4] |=> $stable(FRAC_DIV_OUT))
    else $error("fraction written without gate");
  chk_key_lock: assert property (
    LCR_OUT != 8'hbf |=> $stable(EFR_OUT) && $stable(FLOW_CHARS_OUT))
    else $error("enhanced bank written without key");
  chk_masked_quiet: assert property (s_quiet |-> !INT_OUT)
    else $error("interrupt with all sources masked");
  chk_idle_status: assert property (
    s_quiet ##0 s_stat_rd |=> DATA_OUT[5:0] == 6'h01)
    else $error("status not idle");
  chk_overrun_int: assert property (
    mask_reg[2] && RX_OVERRUN_IN |-> ##[1:2] INT_OUT)
    else $error("overrun interrupt late");
  chk_modem_int: assert property (
    (mask_reg[3] && MSR_IN[3:0] != 4'h0) [*3] |-> INT_OUT)
    else $error("modem interrupt missing");
  chk_line_bits: assert property (s_line_rd |=>
    DATA_OUT[0] == ($past(RX_LEVEL_IN) != '0) &&
    DATA_OUT[4:2] == $past(RX_HEAD_ERR_IN & {3{RX_LEVEL_IN != '0}}) &&
    DATA_OUT[7] == $past(RX_ANY_ERR_IN) &&
    DATA_OUT[5] == ($past(TX_LEVEL_IN) == '0) &&
    DATA_OUT[6] == ($past(TX_LEVEL_IN) == '0 && $past(TSR_EMPTY_IN)))
    else $error("line status bits wrong");
endmodule
bind uie_top uie_asserts #(.LVL_W(LVL_W)) u_chk (.CORE_CLK_IN, .RST_N_IN,
  .CS_IN, .RD_IN, .WR_IN, .ADDR_IN, .DATA_IN, .DATA_OUT, .RX_LEVEL_IN,
  .RX_OVERRUN_IN, .RX_HEAD_ERR_IN, .RX_ANY_ERR_IN, .TX_LEVEL_IN,
  .TSR_EMPTY_IN, .MSR_IN, .SLEEP_EN_OUT, .LCR_OUT, .EFR_OUT,
  .FLOW_CHARS_OUT, .FRAC_DIV_OUT, .INT_OUT);

// [uie_host.sv]
// host bus model for the register port
`timescale 1ns/1ps
module uie_host (
  // clock and read data
  input wire logic clk_in,
  input wire logic [7:0] rdata_in,
  // bus drive
  output logic cs_out,
  output logic rd_out,
  output logic wr_out,
  output logic [2:0] addr_out,
  output logic [7:0] wdata_out
);
  // idle bus at time zero
  initial begin
    cs_out = 1'b0;
    rd_out = 1'b0;
    wr_out = 1'b0;
    addr_out = 3'h0;
    wdata_out = 8'h00;
  end
  // one access held over its taking edge, read data sampled 2 ns after that edge
  task automatic acc(input logic w, input logic [2:0] a,
                     input logic [7:0] d, output logic [7:0] q);
    @(posedge clk_in);
    #2;
    cs_out = 1'b1;
    wr_out = w;
    rd_out = !w;
    addr_out = a;
    wdata_out = d;
    @(posedge clk_in);
    #2;
    cs_out = 1'b0;
    wr_out = 1'b0;
    rd_out = 1'b0;
    wdata_out = ~d; // no stale value
    addr_out = ~a;
    q = rdata_in;
  endtask
endmodule

// [tb.sv]
// self-checking bench for the interrupt block
`timescale 1ns/1ps
module tb;
  localparam logic [5:0] LV [4] = '{6'd16, 6'd15, 6'd28, 6'd0};
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cs, rd, wr, sh_mt, ovr, any_err, pause_det, int_o, sleep, tick;
  logic [2:0] addr, herr;
  logic [7:0] wd, dout, modem, rxd, enh, frac, q, r;
  logic [5:0] rxl, txl;
  logic [31:0] flow;
  logic [31:0] seed = 32'd74;
  logic [7:0] v [4];
  int n_mismatch = 0;
  int total_checks = 0;
  // 40 MHz core clock
  always #12.5 clk = ~clk;
  uie_host host (.clk_in(clk), .rdata_in(dout), .cs_out(cs), .rd_out(rd),
    .wr_out(wr), .addr_out(addr), .wdata_out(wd));
  uie_top #(.LVL_W(6)) dut (.CORE_CLK_IN(clk), .RST_N_IN(rst_n),
    .CS_IN(cs), .RD_IN(rd), .WR_IN(wr), .ADDR_IN(addr), .DATA_IN(wd),
    .DATA_OUT(dout), .RX_LEVEL_IN(rxl), .RX_DATA_IN(rxd),
    .RX_PUSH_IN(1'b0), .RX_OVERRUN_IN(ovr), .RX_HEAD_ERR_IN(herr),
    .RX_ANY_ERR_IN(any_err), .BIT_TICK_IN(tick), .TX_LEVEL_IN(txl),
    .TSR_EMPTY_IN(sh_mt), .MSR_IN(modem), .XOFF_DET_IN(pause_det),
    .XON_DET_IN(1'b0), .RX_POP_OUT(), .TX_PUSH_OUT(), .TX_DATA_OUT(),
    .MSR_READ_OUT(), .RX_FIFO_RST_OUT(), .TX_FIFO_RST_OUT(),
    .FIFO_EN_OUT(), .SLEEP_EN_OUT(sleep), .LCR_OUT(), .MCR_OUT(),
    .EFR_OUT(enh), .FLOW_CHARS_OUT(flow), .DIVISOR_OUT(),
    .FRAC_DIV_OUT(frac), .INT_OUT(int_o));
  ////////////////////////////////////////////////////////////////////////
  // xorshift source
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  // expected line status from the datapath levels
  function automatic logic [7:0] line_exp();
    return {any_err, txl == 6'd0 && sh_mt, txl == 6'd0,
            herr & {3{rxl != 6'd0}}, 1'b0, rxl != 6'd0};
  endfunction
  // compare and count
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // verdict and stop
  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // register access helpers
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    host.acc(1'b1, a, d, q);
  endtask
  task automatic rd_chk(input logic [2:0] a, input logic [7:0] e);
    host.acc(1'b0, a, 8'h00, q);
    check(q, e);
  endtask
  // bounded wait for the interrupt level
  task automatic wait_int(input logic e);
    int i;
    for (i = 0; i < 6 && int_o !== e; i++) begin
      @(posedge clk);
      #2;
    end
    check({7'h00, int_o}, {7'h00, e});
    if (int_o !== e) begin
      end_sim();
    end
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    @(posedge clk);
    #2;
    s = 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    int i;
    {rxl, txl, ovr, herr, any_err, pause_det, modem, rxd, tick} = '0;
    sh_mt = 1'b1;
    repeat (5) @(posedge clk);
    #2;
    rst_n = 1'b1;
    rd_chk(3'h1, 8'h00);
    rd_chk(3'h2, 8'h01);
    // gated bits, prompt transmit interrupt
    wr_reg(3'h1, 8'hf2);
    rd_chk(3'h1, 8'h02);
    wait_int(1'b1);
    rd_chk(3'h2, 8'h02);
    rd_chk(3'h2, 8'h01);
    wait_int(1'b0);
    // enhanced bank under the key
    wr_reg(3'h3, 8'hbf);
    wr_reg(3'h2, 8'h10);
    for (i = 0; i < 4; i++) begin
      v[i] = rnd();
      wr_reg(3'(i + 4), v[i]);
    end
    for (i = 0; i < 4; i++) begin
      rd_chk(3'(i + 4), v[i]);
      check(flow[8*i +: 8], v[i]);
    end
    wr_reg(3'h3, 8'h03);
    wr_reg(3'h2, 8'h00);
    check(enh, 8'h10);
    wr_reg(3'h1, 8'h30);
    rd_chk(3'h1, 8'h30);
    check({7'h00, sleep}, 8'h01);
    pulse(pause_det);
    wait_int(1'b1);
    rd_chk(3'h2, 8'h10);
    wait_int(1'b0);
    // fraction written only with the gate bit
    r = rnd();
    wr_reg(3'h3, 8'h80);
    wr_reg(3'h2, r);
    check(frac, r);
    wr_reg(3'h3, 8'hbf);
    wr_reg(3'h2, 8'h00);
    wr_reg(3'h3, 8'h80);
    wr_reg(3'h2, ~r);
    check(frac, r);
    wr_reg(3'h3, 8'h03);
    rd_chk(3'h1, 8'h00);
    check({7'h00, sleep}, 8'h00);
    // polled line status, random levels and flags
    wr_reg(3'h2, 8'h41);
    for (i = 0; i < 8; i++) begin
      r = rnd();
      rxl = (i == 0) ? 6'd0 : 6'(r % 8'd33);
      txl = (i == 0) ? 6'd0 : 6'(rnd() % 8'd33);
      {herr, any_err, sh_mt} = (i == 0) ? 5'h01 : r[4:0];
      rxd = rnd();
      rd_chk(3'h5, line_exp());
    end
    pulse(ovr);
    rd_chk(3'h5, line_exp() | 8'h02);
    rd_chk(3'h5, line_exp());
    check({7'h00, int_o}, 8'h00);
    // receive trigger at 16
    {herr, any_err} = 4'h0;
    wr_reg(3'h1, 8'h01);
    for (i = 0; i < 4; i++) begin
      rxl = LV[i];
      wait_int(LV[i] >= 6'd16);
      if (LV[i] >= 6'd16) begin
        rd_chk(3'h2, 8'hc4);
      end
    end
    // overrun and head error interrupts
    wr_reg(3'h1, 8'h04);
    pulse(ovr);
    wait_int(1'b1);
    rd_chk(3'h2, 8'hc6);
    rd_chk(3'h5, line_exp() | 8'h02);
    wait_int(1'b0);
    {rxl, herr} = {6'd1, 3'h4};
    wait_int(1'b1);
    rd_chk(3'h5, line_exp());
    wait_int(1'b0);
    // modem change masked, then enabled
    herr = 3'h0;
    modem = 8'h01;
    rd_chk(3'h7, 8'h00);
    check({7'h00, int_o}, 8'h00);
    wr_reg(3'h1, 8'h08);
    wait_int(1'b1);
    rd_chk(3'h2, 8'hc0);
    modem = 8'h00;
    wait_int(1'b0);
    // time-out, 4 chars of 10 bits plus 12 bits
    wr_reg(3'h1, 8'h01);
    tick = 1'b1;
    repeat (50) @(posedge clk);
    #2;
    check({7'h00, int_o}, 8'h00);
    wait_int(1'b1);
    rd_chk(3'h2, 8'hcc);
    rd_chk(3'h0, rxd);
    wait_int(1'b0);
    end_sim();
  end
endmodule
